// *** rtl/slm_pkg.sv ***
// Shared constants and types for the system LED mirror block.
package slm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int          SLM_DATA_W     = 8;
    localparam int          SLM_IND_CNT    = 8;
    localparam logic [6:0]  SLM_DEV_ADDR   = 7'h6B;
    localparam logic [7:0]  SLM_ORANGE_MAP = 8'h17;
    localparam logic [7:0]  SLM_GREEN_MAP  = 8'h18;
    localparam logic [7:0]  SLM_MAP_RESET  = 8'h00;
    localparam logic [7:0]  SLM_RD_UNMAP   = 8'h00;
    localparam logic [3:0]  SLM_BYTE_BITS  = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Indicator positions, shared by both mapping registers.
    localparam int SLM_POWER_MODE_BIT   = 0;
    localparam int SLM_BATTERY_LOW_BIT  = 1;
    localparam int SLM_CHARGING_BIT     = 2;
    localparam int SLM_INFO_BIT         = 3;
    localparam int SLM_COOLER_RUN_BIT   = 4;
    localparam int SLM_RELAY_BIT        = 5;
    localparam int SLM_HOST_VOLTAGE_BIT = 6;
    localparam int SLM_EXT_SUPPLY_BIT   = 7;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        SLM_ST_IDLE,
        SLM_ST_ADDR,
        SLM_ST_ADDR_ACK,
        SLM_ST_WRITE,
        SLM_ST_WRITE_ACK,
        SLM_ST_READ,
        SLM_ST_READ_ACK
    } slm_i2c_state_t;

endpackage : slm_pkg

// *** rtl/slm_i2c_target.sv ***
// Two-wire serial target that turns byte transfers into register accesses.
module slm_i2c_target #(
    parameter logic [6:0] DEV_ADDR = slm_pkg::SLM_DEV_ADDR
) (
    // Clock and reset
    input  wire logic                        ref_clk_in,
    input  wire logic                        resetn_in,
    // Serial pins
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_oe_out,
    // Register side
    input  wire logic [slm_pkg::SLM_DATA_W-1:0] rd_data_in,
    output logic [slm_pkg::SLM_DATA_W-1:0]   addr_out,
    output logic [slm_pkg::SLM_DATA_W-1:0]   wr_data_out,
    output logic                             wr_en_out
);
    import slm_pkg::*;

    logic [2:0]           scl_s_q;
    logic [2:0]           sda_s_q;
    logic                 scl_f_q;
    logic                 sda_f_q;
    logic [3:0]           cnt_q;
    logic [7:0]           shift_q;
    logic [7:0]           tx_q;
    logic                 rw_q;
    logic                 first_q;
    logic                 inc_q;
    logic                 nack_q;
    slm_i2c_state_t       state_q;

    ////////////////////////////////////////////////////////////////////////////
    // A pin change counts only once the second and third stages agree.
    wire scl_d     = (scl_s_q[2] == scl_s_q[1]) ? scl_s_q[1] : scl_f_q;
    wire sda_d     = (sda_s_q[2] == sda_s_q[1]) ? sda_s_q[1] : sda_f_q;
    wire scl_rise  = scl_d & ~scl_f_q;
    wire scl_fall  = ~scl_d & scl_f_q;
    wire bus_start = scl_f_q & scl_d & sda_f_q & ~sda_d;
    wire bus_stop  = scl_f_q & scl_d & ~sda_f_q & sda_d;
    wire byte_done = (cnt_q == SLM_BYTE_BITS);
    wire [2:0] tx_idx = 3'(4'h7 - cnt_q);

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
            scl_f_q <= scl_d;
            sda_f_q <= sda_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q     <= SLM_ST_IDLE;
            cnt_q       <= 4'h0;
            shift_q     <= 8'h00;
            tx_q        <= 8'h00;
            rw_q        <= 1'b0;
            first_q     <= 1'b1;
            inc_q       <= 1'b0;
            nack_q      <= 1'b1;
            sda_oe_out  <= 1'b0;
            addr_out    <= 8'h00;
            wr_data_out <= 8'h00;
            wr_en_out   <= 1'b0;
        end else begin
            wr_en_out <= 1'b0;
            if (bus_start) begin
                state_q    <= SLM_ST_ADDR;
                cnt_q      <= 4'h0;
                first_q    <= 1'b1;
                inc_q      <= 1'b0;
                sda_oe_out <= 1'b0;
            end else if (bus_stop) begin
                state_q    <= SLM_ST_IDLE;
                sda_oe_out <= 1'b0;
            end else if (scl_rise) begin
                if (!byte_done) begin
                    shift_q <= {shift_q[6:0], sda_f_q};
                    cnt_q   <= cnt_q + 4'h1;
                end
                if (state_q == SLM_ST_READ_ACK) begin
                    nack_q <= sda_f_q;
                    // Advance early so the next byte is ready at the fall.
                    if (!sda_f_q) begin
                        addr_out <= addr_out + 8'h01;
                    end
                end
            end else if (scl_fall) begin
                case (state_q)
                    SLM_ST_ADDR: begin
                        if (byte_done && shift_q[7:1] == DEV_ADDR) begin
                            sda_oe_out <= 1'b1;
                            rw_q       <= shift_q[0];
                            state_q    <= SLM_ST_ADDR_ACK;
                        end else if (byte_done) begin
                            state_q <= SLM_ST_IDLE;
                        end
                    end
                    SLM_ST_ADDR_ACK: begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            tx_q       <= rd_data_in;
                            sda_oe_out <= ~rd_data_in[7];
                            state_q    <= SLM_ST_READ;
                        end else begin
                            sda_oe_out <= 1'b0;
                            state_q    <= SLM_ST_WRITE;
                        end
                    end
                    SLM_ST_WRITE: begin
                        if (byte_done) begin
                            sda_oe_out <= 1'b1;
                            state_q    <= SLM_ST_WRITE_ACK;
                            if (first_q) begin
                                addr_out <= shift_q;
                                first_q  <= 1'b0;
                            end else begin
                                wr_en_out   <= 1'b1;
                                wr_data_out <= shift_q;
                                inc_q       <= 1'b1;
                            end
                        end
                    end
                    SLM_ST_WRITE_ACK: begin
                        sda_oe_out <= 1'b0;
                        cnt_q      <= 4'h0;
                        inc_q      <= 1'b0;
                        state_q    <= SLM_ST_WRITE;
                        if (inc_q) begin
                            addr_out <= addr_out + 8'h01;
                        end
                    end
                    SLM_ST_READ: begin
                        if (byte_done) begin
                            sda_oe_out <= 1'b0;
                            state_q    <= SLM_ST_READ_ACK;
                        end else begin
                            sda_oe_out <= ~tx_q[tx_idx];
                        end
                    end
                    SLM_ST_READ_ACK: begin
                        if (!nack_q) begin
                            tx_q       <= rd_data_in;
                            sda_oe_out <= ~rd_data_in[7];
                            cnt_q      <= 4'h0;
                            state_q    <= SLM_ST_READ;
                        end else begin
                            state_q <= SLM_ST_IDLE;
                        end
                    end
                    default: begin
                        sda_oe_out <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule : slm_i2c_target

// *** rtl/slm_led_mirror.sv ***
// System LED mirror: mapping registers that copy system indicators onto user LEDs.
module slm_led_mirror #(
    parameter logic [6:0] DEV_ADDR = slm_pkg::SLM_DEV_ADDR
) (
    // Clock and reset
    input  wire logic                          ref_clk_in,
    input  wire logic                          resetn_in,
    // Serial command pins
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe_out,
    // System indicators from the device logic
    input  wire logic [slm_pkg::SLM_IND_CNT-1:0] sys_ind_in,
    // Direct on/off commands for orange (bit 0) and green (bit 1)
    input  wire logic [1:0]                    direct_wr_in,
    input  wire logic [1:0]                    direct_val_in,
    // LED drives
    output logic [slm_pkg::SLM_IND_CNT-1:0]    sys_led_out,
    output logic                               orange_led_out,
    output logic                               green_led_out
);
    import slm_pkg::*;

    logic [7:0] orange_map_q;
    logic [7:0] green_map_q;
    logic [7:0] orange_sel_q;
    logic [7:0] green_sel_q;
    logic       sda_q;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic [7:0] reg_rdata;

    function automatic logic mirror_or(input logic [7:0] map, input logic [7:0] ind);
        return |(map & ind);
    endfunction : mirror_or

    ////////////////////////////////////////////////////////////////////////////
    // The serial target owns pointer handling; this level only decodes map addresses.
    slm_i2c_target #(.DEV_ADDR(DEV_ADDR)) u_target (
        .ref_clk_in  (ref_clk_in),
        .resetn_in   (resetn_in),
        .scl_in      (scl_in),
        .sda_in      (sda_in),
        .sda_oe_out  (sda_oe_out),
        .rd_data_in  (reg_rdata),
        .addr_out    (reg_addr),
        .wr_data_out (reg_wdata),
        .wr_en_out   (reg_wr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // The pin is open drain: it only ever pulls low while enabled.
    assign sda_out = sda_q;

    wire       wr_orange  = reg_wr && (reg_addr == SLM_ORANGE_MAP);
    wire       wr_green   = reg_wr && (reg_addr == SLM_GREEN_MAP);
    // Unmapped pointers read as zero, so a host scan sees no stray bits.
    assign reg_rdata = (reg_addr == SLM_ORANGE_MAP) ? orange_map_q :
                       (reg_addr == SLM_GREEN_MAP)  ? green_map_q  : SLM_RD_UNMAP;
    wire [7:0] orange_sel = orange_map_q & sys_ind_in;
    wire [7:0] green_sel  = green_map_q & sys_ind_in;
    // An update is any change in the selected indicators, a map write included.
    // A map cleared to zero is no update: the LED keeps its value until commanded.
    wire       orange_upd = (orange_map_q != 8'h00) && (orange_sel != orange_sel_q);
    wire       green_upd  = (green_map_q != 8'h00) && (green_sel != green_sel_q);
    wire       orange_led_d = orange_upd      ? mirror_or(orange_map_q, sys_ind_in) :
                              direct_wr_in[0] ? direct_val_in[0] : orange_led_out;
    wire       green_led_d  = green_upd       ? mirror_or(green_map_q, sys_ind_in) :
                              direct_wr_in[1] ? direct_val_in[1] : green_led_out;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            orange_map_q <= SLM_MAP_RESET;
            green_map_q  <= SLM_MAP_RESET;
            sda_q        <= 1'b0;
        end else begin
            if (wr_orange) begin
                orange_map_q <= reg_wdata;
            end
            if (wr_green) begin
                green_map_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            orange_sel_q   <= 8'h00;
            green_sel_q    <= 8'h00;
            sys_led_out    <= 8'h00;
            orange_led_out <= 1'b0;
            green_led_out  <= 1'b0;
        end else begin
            orange_sel_q <= orange_sel;
            green_sel_q  <= green_sel;
            sys_led_out <= sys_ind_in;
            orange_led_out <= orange_led_d;
            green_led_out  <= green_led_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    orange_store_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        wr_orange |=> orange_map_q == $past(reg_wdata))
        else $error("orange map did not take the written byte");

    battery_to_orange_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h02 && $changed(sys_ind_in[SLM_BATTERY_LOW_BIT]))
        |=> orange_led_out == $past(sys_ind_in[SLM_BATTERY_LOW_BIT]))
        else $error("battery low indicator not mirrored on orange");

    cooler_to_orange_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h10 && $rose(sys_ind_in[SLM_COOLER_RUN_BIT]))
        |=> orange_led_out)
        else $error("cooler run indicator not mirrored on orange");

    supply_to_orange_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h80 && $changed(sys_ind_in[SLM_EXT_SUPPLY_BIT]))
        |=> orange_led_out == $past(sys_ind_in[SLM_EXT_SUPPLY_BIT]))
        else $error("external supply indicator not mirrored on orange");

    power_to_green_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (green_map_q == 8'h01 && $changed(sys_ind_in[SLM_POWER_MODE_BIT]))
        |=> green_led_out == $past(sys_ind_in[SLM_POWER_MODE_BIT]))
        else $error("power mode indicator not mirrored on green");

    sys_passthru_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        $changed(sys_ind_in) |=> sys_led_out == $past(sys_ind_in))
        else $error("system LED altered by mapping");

    direct_cmd_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (direct_wr_in[1] && !green_upd) |=> green_led_out == $past(direct_val_in[1]))
        else $error("direct green command ignored");

    multi_source_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h21 && orange_upd)
        |=> orange_led_out ==
            $past(sys_ind_in[SLM_POWER_MODE_BIT] | sys_ind_in[SLM_RELAY_BIT]))
        else $error("two mapped indicators not combined");

    unmapped_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h00 && !direct_wr_in[0]) |=> $stable(orange_led_out))
        else $error("unmapped orange LED changed without command");

    green_store_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        wr_green |=> green_map_q == $past(reg_wdata))
        else $error("green map did not take the written byte");

    power_to_orange_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h01 && $stable(orange_map_q)
            && $changed(sys_ind_in[SLM_POWER_MODE_BIT]))
        |=> orange_led_out == $past(sys_ind_in[SLM_POWER_MODE_BIT]))
        else $error("power mode indicator not mirrored on orange");

    charging_to_orange_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h04 && $stable(orange_map_q)
            && $changed(sys_ind_in[SLM_CHARGING_BIT]))
        |=> orange_led_out == $past(sys_ind_in[SLM_CHARGING_BIT]))
        else $error("charging indicator not mirrored on orange");

    info_to_orange_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h08 && $stable(orange_map_q)
            && $changed(sys_ind_in[SLM_INFO_BIT]))
        |=> orange_led_out == $past(sys_ind_in[SLM_INFO_BIT]))
        else $error("info indicator not mirrored on orange");

    relay_to_orange_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h20 && $stable(orange_map_q)
            && $changed(sys_ind_in[SLM_RELAY_BIT]))
        |=> orange_led_out == $past(sys_ind_in[SLM_RELAY_BIT]))
        else $error("relay indicator not mirrored on orange");

    host_volt_orange_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q == 8'h40 && $stable(orange_map_q)
            && $changed(sys_ind_in[SLM_HOST_VOLTAGE_BIT]))
        |=> orange_led_out == $past(sys_ind_in[SLM_HOST_VOLTAGE_BIT]))
        else $error("host voltage indicator not mirrored on orange");

    direct_orange_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (direct_wr_in[0] && !orange_upd) |=> orange_led_out == $past(direct_val_in[0]))
        else $error("direct orange command ignored");

    update_wins_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_upd && direct_wr_in[0])
        |=> orange_led_out == $past(|(orange_map_q & sys_ind_in)))
        else $error("direct command beat a mirror update");

    orange_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (orange_map_q != 8'h00 && !orange_upd && !direct_wr_in[0])
        |=> $stable(orange_led_out))
        else $error("mapped orange LED changed without update");

    green_unmapped_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (green_map_q == 8'h00 && !direct_wr_in[1]) |=> $stable(green_led_out))
        else $error("unmapped green LED changed without command");

endmodule : slm_led_mirror

// *** verif/slm_host_model.sv ***
// Host serial master model that issues register writes and reads.
module slm_host_model (
    // Clock
    input  wire logic ref_clk_in,
    // Serial lines
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_pull_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import slm_pkg::*;

    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Eight cycles a phase gives twice the margin the target's filters need.
    task automatic half_phase();
        repeat (8) @(posedge ref_clk_in);
        #1;
    endtask : half_phase

    // Serves as start and repeated start alike.
    task automatic start_cond();
        sda_pull_out = 1'b0;
        half_phase();
        scl_out = 1'b1;
        half_phase();
        sda_pull_out = 1'b1;
        half_phase();
        scl_out = 1'b0;
        half_phase();
    endtask : start_cond

    task automatic stop_cond();
        sda_pull_out = 1'b1;
        half_phase();
        scl_out = 1'b1;
        half_phase();
        sda_pull_out = 1'b0;
        half_phase();
    endtask : stop_cond

    // Data moves only while the clock is low; it is sampled late in the high phase.
    task automatic xfer_bit(input logic tx, output logic rx);
        sda_pull_out = !tx;
        half_phase();
        scl_out = 1'b1;
        half_phase();
        rx = sda_in;
        scl_out = 1'b0;
        half_phase();
    endtask : xfer_bit

    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(tx[i], rx[i]);
        end
    endtask : xfer_byte

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] data, output logic [2:0] nack);
        logic [7:0] rx;
        start_cond();
        xfer_byte({dev, 1'b0}, rx);
        xfer_bit(1'b1, nack[2]);
        xfer_byte(ptr, rx);
        xfer_bit(1'b1, nack[1]);
        xfer_byte(data, rx);
        xfer_bit(1'b1, nack[0]);
        stop_cond();
    endtask : write_reg

    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data);
        logic [7:0] rx;
        logic       ack;
        start_cond();
        xfer_byte({SLM_DEV_ADDR, 1'b0}, rx);
        xfer_bit(1'b1, ack);
        xfer_byte(ptr, rx);
        xfer_bit(1'b1, ack);
        start_cond();
        xfer_byte({SLM_DEV_ADDR, 1'b1}, rx);
        xfer_bit(1'b1, ack);
        xfer_byte(8'hFF, data);
        xfer_bit(1'b1, ack);
        stop_cond();
    endtask : read_reg
endmodule : slm_host_model

// *** verif/tb.sv ***
// Self-checking bench for the system LED mirror block.
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import slm_pkg::*;

    logic       ref_clk_in;
    logic       resetn_in;
    logic       scl;
    logic       sda_pull;
    logic       sda_oe;
    logic       sda_drv;
    wire        sda_wire;
    logic [7:0] sys_ind;
    logic [7:0] sys_led;
    logic [1:0] direct_wr;
    logic [1:0] direct_val;
    logic       orange;
    logic       green;
    logic [7:0] rd;
    logic [2:0] nack;
    int         fail_count;
    int         checked;
    int         cycles;

    // The data line is pulled up; any party may pull it low.
    // While enabled the device puts its output value on the line.
    assign sda_wire = !sda_pull && (sda_oe ? sda_drv : 1'b1);

    slm_host_model slm_host_model_i (.ref_clk_in(ref_clk_in), .sda_in(sda_wire),
        .scl_out(scl), .sda_pull_out(sda_pull));

    slm_led_mirror #(.DEV_ADDR(SLM_DEV_ADDR)) slm_led_mirror_i (
        .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_drv), .sda_oe_out(sda_oe),
        .sys_ind_in(sys_ind), .direct_wr_in(direct_wr), .direct_val_in(direct_val),
        .sys_led_out(sys_led), .orange_led_out(orange), .green_led_out(green));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic tick();
        @(posedge ref_clk_in);
        #1;
    endtask : tick

    task automatic set_ind(input logic [7:0] v);
        sys_ind = v;
        tick();
        `CHK(sys_led, v)
    endtask : set_ind

    task automatic direct(input logic [1:0] wr, input logic [1:0] val, input logic [7:0] v);
        direct_wr = wr;
        direct_val = val;
        sys_ind = v;
        tick();
        direct_wr = 2'b00;
    endtask : direct

    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        slm_host_model_i.write_reg(SLM_DEV_ADDR, ptr, data, nack);
        `CHK(nack, 3'b000)
    endtask : wr

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_orange_bits();
        slm_host_model_i.read_reg(SLM_ORANGE_MAP, rd);
        `CHK(rd, SLM_MAP_RESET)
        for (int i = 0; i < 8; i++) begin
            set_ind(8'h00);
            wr(SLM_ORANGE_MAP, 8'h01 << i);
            slm_host_model_i.read_reg(SLM_ORANGE_MAP, rd);
            `CHK(rd, 8'h01 << i)
            set_ind(8'h01 << i);
            `CHK(orange, 1'b1)
            set_ind(~(8'h01 << i));
            `CHK(orange, 1'b0)
            `CHK(green, 1'b0)
        end
        $display("test orange_bits done");
    endtask : test_orange_bits

    task automatic test_green();
        set_ind(8'h00);
        wr(SLM_GREEN_MAP, 8'h01);
        slm_host_model_i.read_reg(SLM_GREEN_MAP, rd);
        `CHK(rd, 8'h01)
        set_ind(8'h01);
        `CHK(green, 1'b1)
        `CHK(orange, 1'b0)
        set_ind(8'hFE);
        `CHK(green, 1'b0)
        $display("test green done");
    endtask : test_green

    task automatic test_or();
        set_ind(8'h00);
        wr(SLM_ORANGE_MAP, 8'h21);
        set_ind(8'h01);
        `CHK(orange, 1'b1)
        set_ind(8'h21);
        `CHK(orange, 1'b1)
        set_ind(8'h20);
        `CHK(orange, 1'b1)
        set_ind(8'h00);
        `CHK(orange, 1'b0)
        $display("test or done");
    endtask : test_or

    task automatic test_direct();
        direct(2'b01, 2'b01, 8'h00);
        `CHK(orange, 1'b1)
        set_ind(8'h01);
        set_ind(8'h00);
        `CHK(orange, 1'b0)
        // A mirror update in the same cycle beats the command.
        direct(2'b01, 2'b00, 8'h20);
        `CHK(orange, 1'b1)
        set_ind(8'h00);
        wr(SLM_GREEN_MAP, 8'h00);
        direct(2'b10, 2'b10, 8'h00);
        `CHK(green, 1'b1)
        set_ind(8'hFF);
        `CHK(green, 1'b1)
        direct(2'b10, 2'b00, 8'hFF);
        `CHK(green, 1'b0)
        $display("test direct done");
    endtask : test_direct

    task automatic test_bus();
        wr(8'h19, 8'hFF);
        slm_host_model_i.read_reg(8'h19, rd);
        `CHK(rd, SLM_RD_UNMAP)
        slm_host_model_i.write_reg(SLM_DEV_ADDR ^ 7'h01, SLM_ORANGE_MAP, 8'hAA, nack);
        `CHK(nack, 3'b111)
        slm_host_model_i.read_reg(SLM_ORANGE_MAP, rd);
        `CHK(rd, 8'h21)
        $display("test bus done");
    endtask : test_bus

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    // A full run needs about 21000 cycles; the ceiling leaves margin.
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 50000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        resetn_in = 1'b0;
        sys_ind = 8'h00;
        direct_wr = 2'b00;
        direct_val = 2'b00;
        repeat (10) @(posedge ref_clk_in);
        #1;
        resetn_in = 1'b1;
        repeat (4) tick();
        test_orange_bits();
        test_green();
        test_or();
        test_direct();
        test_bus();
        end_of_test();
    end
endmodule : tb
